/* err_pkg.sv */
// Constants shared by the command error reporter and its text store.
// Assumes an ASCII byte stream with one byte per strobe.
package err_pkg;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CODE_BAD_CHAN = 8'h01;
  localparam logic [7:0] CODE_SYNTAX = 8'h03;
  localparam logic [7:0] CODE_TASK = 8'h04;
  localparam logic [7:0] CODE_LINE = 8'h09;
  localparam logic [1:0] TXT_UNKNOWN = 2'h0;
  localparam logic [1:0] TXT_PARTIAL = 2'h1;
  localparam logic [1:0] TXT_SELECT = 2'h2;
  localparam logic [5:0] TXT_LEN_UNKNOWN = 6'h1D;
  localparam logic [5:0] TXT_LEN_PARTIAL = 6'h25;
  localparam logic [5:0] TXT_LEN_SELECT = 6'h2C;
  localparam int ECHO_DEPTH = 32;
  localparam logic [4:0] ECHO_LAST = 5'h1F;
  localparam logic [7:0] UNIT_RESET = 8'h00;
endpackage

/* err_text_rom.sv */
// Character store for the three full-text error messages.
// Assumes a message id and a character index; answers combinationally.
`timescale 1ns/1ps
`default_nettype none
module err_text_rom (
  input wire logic [1:0] msg_id, // Which message.
  input wire logic [5:0] idx, // Character index.
  output logic [7:0] ch // Character at the index.
);
  // Packed vectors keep the text synthesizable; the first character sits in the top byte.
  localparam logic [231:0] S_UNK = "Error, Unrecognized Command: ";
  localparam logic [295:0] S_PAR = "Error, Command not fully recognized: ";
  localparam logic [351:0] S_SEL = "Error, Address command must be CR terminated";

  // Every message starts with the same prefix and comma.
  always_comb
  begin
    ch = 8'h20;
    unique case (msg_id)
      err_pkg::TXT_UNKNOWN:
      begin
        if (idx < err_pkg::TXT_LEN_UNKNOWN)
          ch = S_UNK[8 * (int'(err_pkg::TXT_LEN_UNKNOWN) - 1 - int'(idx)) +: 8];
      end
      err_pkg::TXT_PARTIAL:
      begin
        if (idx < err_pkg::TXT_LEN_PARTIAL)
          ch = S_PAR[8 * (int'(err_pkg::TXT_LEN_PARTIAL) - 1 - int'(idx)) +: 8];
      end
      default:
      begin
        if (idx < err_pkg::TXT_LEN_SELECT)
          ch = S_SEL[8 * (int'(err_pkg::TXT_LEN_SELECT) - 1 - int'(idx)) +: 8];
      end
    endcase
  end
endmodule // err_text_rom
`default_nettype wire

/* command_error_reporter.sv */
// Error detection and reporting stage of the ASCII command interpreter.
// Assumes a parser upstream that flags each command's faults at its end.
`timescale 1ns/1ps
`default_nettype none
module command_error_reporter (
  input wire logic core_clk, // Core clock, 50 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic rx_valid, // One received byte this cycle.
  input wire logic [7:0] rx_data, // Received byte.
  input wire logic rx_line_err, // Parity or framing fault on this byte.
  input wire logic cmd_end, // Pulse: command complete, flags below valid.
  input wire logic f_bad_chan, // Channel not a number or above 07.
  input wire logic f_syntax, // Improper syntax.
  input wire logic f_task, // Channel unfit for the task.
  input wire logic f_unknown, // Leading letter unknown.
  input wire logic f_partial, // Letter known, rest unknown.
  input wire logic f_sel_extra, // Unit select had extra characters.
  input wire logic sel_ok, // Valid unit select command.
  input wire logic [7:0] sel_unit, // Unit number of that select.
  input wire logic tx_ready, // Transmitter takes a byte.
  output logic tx_valid, // Byte offered.
  output logic [7:0] tx_data, // Byte offered.
  output logic err_flag, // Pulse: command failed, normal reply suppressed.
  output logic [7:0] active_unit, // Currently selected unit.
  output logic busy // Reply in progress.
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_CODE = 5'b00010,
    S_TEXT = 5'b00100,
    S_ECHO = 5'b01000,
    S_CR = 5'b10000
  } state_t;

  typedef struct packed {
    state_t st;
    logic line_err;
    logic [7:0] code;
    logic [1:0] msg;
    logic [5:0] idx;
    logic [4:0] wr;
    logic [4:0] rd;
    logic echo;
    logic tx_valid;
    logic [7:0] tx_data;
    logic err_flag;
    logic [7:0] unit;
    logic busy;
  } regs_t;

  regs_t r_ff, nxt_r;
  logic [7:0] echo_mem [err_pkg::ECHO_DEPTH];
  logic [7:0] rom_ch;
  logic [5:0] txt_len;

  err_text_rom u_rom (
    .msg_id(r_ff.msg),
    .idx(r_ff.idx),
    .ch(rom_ch)
  );

  // Message length for the selected text.
  always_comb
  begin
    unique case (r_ff.msg)
      err_pkg::TXT_UNKNOWN: txt_len = err_pkg::TXT_LEN_UNKNOWN;
      err_pkg::TXT_PARTIAL: txt_len = err_pkg::TXT_LEN_PARTIAL;
      default: txt_len = err_pkg::TXT_LEN_SELECT;
    endcase
  end

  // Echo store keeps the command bytes, without the terminator.
  always_ff @(posedge core_clk)
  begin
    if (r_ff.st == S_IDLE && rx_valid && rx_data != err_pkg::CH_CR && r_ff.wr != err_pkg::ECHO_LAST)
      echo_mem[r_ff.wr] <= rx_data;
  end

  // Next-state logic: collect faults, then pick and emit one reply.
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.err_flag = 1'b0;
    if (r_ff.tx_valid && tx_ready)
      nxt_r.tx_valid = 1'b0;
    unique case (r_ff.st)
      S_IDLE:
      begin
        if (rx_valid)
        begin
          if (rx_line_err)
            nxt_r.line_err = 1'b1;
          if (rx_data != err_pkg::CH_CR && r_ff.wr != err_pkg::ECHO_LAST)
            nxt_r.wr = r_ff.wr + 5'h01;
        end
        if (cmd_end)
        begin
          nxt_r.rd = '0;
          nxt_r.idx = '0;
          nxt_r.line_err = 1'b0;
          nxt_r.err_flag = 1'b1;
          nxt_r.st = S_CODE;
          if (r_ff.line_err || (rx_valid && rx_line_err))
            nxt_r.code = err_pkg::CODE_LINE;
          else if (f_unknown)
          begin
            nxt_r.msg = err_pkg::TXT_UNKNOWN;
            nxt_r.echo = 1'b1;
            nxt_r.st = S_TEXT;
          end
          else if (f_partial)
          begin
            nxt_r.msg = err_pkg::TXT_PARTIAL;
            nxt_r.echo = 1'b1;
            nxt_r.st = S_TEXT;
          end
          else if (f_sel_extra)
          begin
            nxt_r.msg = err_pkg::TXT_SELECT;
            nxt_r.echo = 1'b0;
            nxt_r.st = S_TEXT;
          end
          else if (f_syntax)
            nxt_r.code = err_pkg::CODE_SYNTAX;
          else if (f_bad_chan)
            nxt_r.code = err_pkg::CODE_BAD_CHAN;
          else if (f_task)
            nxt_r.code = err_pkg::CODE_TASK;
          else
          begin
            nxt_r.err_flag = 1'b0;
            nxt_r.st = S_IDLE;
            nxt_r.wr = '0; // A failing command keeps its count for the echo.
            if (sel_ok)
              nxt_r.unit = sel_unit;
          end
        end
      end
      S_CODE:
      begin
        if (!r_ff.tx_valid)
        begin
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_data = err_pkg::CH_ZERO + r_ff.code;
          nxt_r.st = S_CR;
        end
      end
      S_TEXT:
      begin
        if (!r_ff.tx_valid || tx_ready)
        begin
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_data = rom_ch;
          nxt_r.idx = r_ff.idx + 6'h01;
          if (r_ff.idx + 6'h01 == txt_len)
            nxt_r.st = (r_ff.echo && r_ff.wr != 5'h00) ? S_ECHO : S_CR;
        end
      end
      S_ECHO:
      begin
        if (!r_ff.tx_valid || tx_ready)
        begin
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_data = echo_mem[r_ff.rd];
          nxt_r.rd = r_ff.rd + 5'h01;
          if (r_ff.rd + 5'h01 == r_ff.wr)
            nxt_r.st = S_CR;
        end
      end
      S_CR:
      begin
        if (!r_ff.tx_valid || tx_ready)
        begin
          nxt_r.tx_valid = 1'b1;
          nxt_r.tx_data = err_pkg::CH_CR;
          nxt_r.wr = '0;
          nxt_r.st = S_IDLE;
        end
      end
      default: nxt_r.st = S_IDLE;
    endcase
    // Busy is registered so that the output comes straight from a flip-flop.
    nxt_r.busy = (nxt_r.st != S_IDLE);
  end

  // Echo write count is kept during the reply and cleared at its end.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      r_ff <= '{st: S_IDLE, unit: err_pkg::UNIT_RESET, default: '0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign tx_valid = r_ff.tx_valid;
  assign tx_data = r_ff.tx_data;
  assign err_flag = r_ff.err_flag;
  assign active_unit = r_ff.unit;
  assign busy = r_ff.busy;

  sequence s_code_sent;
    tx_valid && tx_data != err_pkg::CH_CR;
  endsequence

  property p_line;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_IDLE && cmd_end && r_ff.line_err) |=> r_ff.code == err_pkg::CODE_LINE;
  endproperty
  a_line: assert property (p_line) else $error("line fault did not give code 9");

  property p_chan;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_IDLE && cmd_end && !r_ff.line_err && !rx_line_err && !f_unknown && !f_partial
       && !f_sel_extra && !f_syntax && f_bad_chan) |=> r_ff.code == err_pkg::CODE_BAD_CHAN;
  endproperty
  a_chan: assert property (p_chan) else $error("bad channel did not give code 1");

  property p_syn;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_IDLE && cmd_end && !r_ff.line_err && !rx_line_err && !f_unknown && !f_partial
       && !f_sel_extra && f_syntax) |=> r_ff.code == err_pkg::CODE_SYNTAX;
  endproperty
  a_syn: assert property (p_syn) else $error("syntax fault did not give code 3");

  property p_task;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_IDLE && cmd_end && !r_ff.line_err && !rx_line_err && !f_unknown && !f_partial
       && !f_sel_extra && !f_syntax && !f_bad_chan && f_task) |=> r_ff.code == err_pkg::CODE_TASK;
  endproperty
  a_task: assert property (p_task) else $error("task fault did not give code 4");

  property p_digit_cr;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_CODE && !tx_valid) |=> s_code_sent ##1 (tx_valid && !tx_ready)[*1] or
      (s_code_sent ##[1:8] (tx_valid && tx_data == err_pkg::CH_CR));
  endproperty
  a_digit_cr: assert property (p_digit_cr) else $error("code digit not followed by CR");

  property p_text_first;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_IDLE && $past(r_ff.st) == S_IDLE && busy == 1'b0 && !tx_valid && nxt_r.st == S_TEXT)
      |=> ##1 (tx_valid && tx_data == 8'h45);
  endproperty
  a_text_first: assert property (p_text_first) else $error("text message does not start with E");

  property p_unknown;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_IDLE && cmd_end && !r_ff.line_err && !rx_line_err && f_unknown)
      |=> (r_ff.st == S_TEXT && r_ff.msg == err_pkg::TXT_UNKNOWN && r_ff.echo);
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown command not reported");

  property p_partial;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_IDLE && cmd_end && !r_ff.line_err && !rx_line_err && !f_unknown && f_partial)
      |=> (r_ff.st == S_TEXT && r_ff.msg == err_pkg::TXT_PARTIAL && r_ff.echo);
  endproperty
  a_partial: assert property (p_partial) else $error("partial command not reported");

  property p_sel;
    @(posedge core_clk) disable iff (rst)
      (r_ff.st == S_IDLE && cmd_end && !r_ff.line_err && !rx_line_err && !f_unknown && !f_partial
       && f_sel_extra) |=> (r_ff.msg == err_pkg::TXT_SELECT && !r_ff.echo && $stable(active_unit));
  endproperty
  a_sel: assert property (p_sel) else $error("bad unit select not rejected");

  property p_unit_hold;
    @(posedge core_clk) disable iff (rst)
      !(r_ff.st == S_IDLE && cmd_end && sel_ok) |=> $stable(active_unit);
  endproperty
  a_unit_hold: assert property (p_unit_hold) else $error("unit changed without select");
endmodule // command_error_reporter
`default_nettype wire

/* host_sink.sv */
// Host model that drains the reporter's reply bytes.
// Assumes tx_valid holds its byte until an edge with tx_ready high.
`timescale 1ns/1ps
`default_nettype none
module host_sink (
  input wire logic core_clk, // Core clock.
  input wire logic rst, // Reset, active high.
  input wire logic tx_valid, // Byte offered.
  input wire logic [7:0] tx_data, // Byte offered.
  input wire logic slow, // Stall at random when high.
  output var logic tx_ready // Byte taken at this edge.
);
  logic [7:0] got[$];
  // Stores each accepted byte, then picks the next ready level.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_ready <= 1'b0;
    end
    else
    begin
      if (tx_valid === 1'b1 && tx_ready)
      begin
        got.push_back(tx_data);
      end
      tx_ready <= slow ? 1'($urandom % 2) : 1'b1;
    end
  end
endmodule // host_sink
`default_nettype wire

/* tb.sv */
// Self-checking bench for the command error reporter.
// Assumes the reporter replies only to failing commands.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk, rst, rx_valid, rx_line_err, cmd_end, sel_ok, tx_ready, tx_valid, err_flag, busy, slow;
  logic [7:0] rx_data, sel_unit, tx_data, active_unit, exp_unit;
  logic [5:0] f;
  int fail_count, cmp_count;
  command_error_reporter u_dut (.core_clk(core_clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_line_err(rx_line_err), .cmd_end(cmd_end), .f_bad_chan(f[0]), .f_syntax(f[1]), .f_task(f[2]),
    .f_unknown(f[3]), .f_partial(f[4]), .f_sel_extra(f[5]), .sel_ok(sel_ok), .sel_unit(sel_unit),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .err_flag(err_flag),
    .active_unit(active_unit), .busy(busy));
  host_sink u_host (.core_clk(core_clk), .rst(rst), .tx_valid(tx_valid), .tx_data(tx_data), .slow(slow),
    .tx_ready(tx_ready));
  // Counts a comparison and reports a failing one.
  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  // Sends one command, models the expected reply and compares it.
  task automatic run_cmd(input string s, input logic [5:0] fl, input int bad, input bit so, input bit dup);
    logic [7:0] t[$];
    string p;
    string m;
    int n;
    bit txt;
    p = "Error,";
    m = "";
    txt = (bad < 0) && (fl[5:3] != 3'h0);
    // Full text of the expected message, by priority among the text faults.
    if (txt && fl[3])
      m = "Error, Unrecognized Command: ";
    else if (txt && fl[4])
      m = "Error, Command not fully recognized: ";
    else if (txt)
      m = "Error, Address command must be CR terminated";
    t = {};
    foreach (m[i]) t.push_back(m[i]);
    if (bad >= 0) t = '{err_pkg::CH_ZERO + err_pkg::CODE_LINE};
    else if (fl[3] || fl[4]) foreach (s[i]) t.push_back(s[i]);
    else if (!fl[5] && fl[1]) t = '{err_pkg::CH_ZERO + err_pkg::CODE_SYNTAX};
    else if (!fl[5] && fl[0]) t = '{err_pkg::CH_ZERO + err_pkg::CODE_BAD_CHAN};
    else if (!fl[5] && fl[2]) t = '{err_pkg::CH_ZERO + err_pkg::CODE_TASK};
    if (txt || t.size() > 0) t.push_back(err_pkg::CH_CR);
    u_host.got = {};
    foreach (s[i])
    begin
      @(posedge core_clk);
      #1;
      rx_valid = 1'b1;
      rx_data = s[i];
      rx_line_err = (i == bad);
    end
    @(posedge core_clk);
    #1;
    rx_valid = 1'b0;
    rx_line_err = 1'b0;
    cmd_end = 1'b1;
    f = fl;
    sel_ok = so;
    sel_unit = 8'($urandom);
    if (so && bad < 0 && fl == 6'h00) exp_unit = sel_unit;
    @(posedge core_clk);
    #1;
    cmd_end = dup;
    f = dup ? 6'h02 : 6'h00;
    sel_ok = 1'b0;
    check(err_flag === (t.size() > 0), "error pulse");
    check(busy === (t.size() > 0), "busy flag");
    @(posedge core_clk);
    #1;
    cmd_end = 1'b0;
    f = 6'h00;
    n = 0;
    while ((busy !== 1'b0 || tx_valid !== 1'b0) && n < 3000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n < 3000, "reply timeout");
    check(u_host.got.size() == t.size(), "reply length");
    if (txt) for (int i = 0; i < 6; i++) check(u_host.got[i] === p[i], "text prefix");
    foreach (t[i]) check(u_host.got[i] === t[i], "reply byte");
    check(active_unit === exp_unit, "active unit");
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Free-running core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Cuts a hang short.
  initial
  begin
    #1000000;
    fail_count++;
    end_of_test;
  end
  // Main sequence, once with a prompt host and once with a stalling one.
  initial
  begin
    void'($urandom(32'h17274B21));
    {rst, rx_valid, rx_line_err, cmd_end, sel_ok, slow} = 6'h20;
    rx_data = 8'h00;
    sel_unit = 8'h00;
    f = 6'h00;
    exp_unit = err_pkg::UNIT_RESET;
    repeat (20) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check(active_unit === err_pkg::UNIT_RESET && tx_valid === 1'b0, "reset values");
    for (int r = 0; r < 2; r++)
    begin
      slow = r[0];
      run_cmd("O9+", 6'h01, -1, 1'b0, 1'b0);
      run_cmd("O2", 6'h07, -1, 1'b0, 1'b1);
      run_cmd("O7+", 6'h04, -1, 1'b0, 1'b0);
      run_cmd("OAA", 6'h0F, 1, 1'b0, 1'b0);
      run_cmd("Qx", 6'h0B, -1, 1'b0, 1'b0);
      run_cmd("Cx5", 6'h12, -1, 1'b0, 1'b0);
      run_cmd("!05z", 6'h20, -1, 1'b1, 1'b0);
      run_cmd("!03", 6'h00, -1, 1'b1, 1'b0);
      run_cmd("I", 6'h00, -1, 1'b0, 1'b0);
    end
    end_of_test;
  end
endmodule // tb
`default_nettype wire
